// File: src/udt_timer.sv
// What this block does
// [R1] Sixteen-bit count from two cascaded bytes
// [R2] Counter select: clock/12 or count pin
// [R3] Count advances only while run bit set
// [R4] Capture, reload, baud chosen by three bits
// [R5] Down-count enable: direction pin picks up/down
// [R6] Up overflow at FFFF: flag, irq, reload; capture mode loads 0000 instead
// [R7] Down underflow at reload: flag, load FFFF
// [R8] Up/down wrap toggles external flag, no irq
// [R9] Clock-output mode gives 50% duty clock
// [R10] Clock-output counts at half peripheral clock
// [R11] Clock-output overflow reloads, raises no irq
// [R12] Output frequency clock/(4*(65536-reload))
// [R13] Generated clock driven on count pin
// [R14] Software sets up clock-out before run
// [R15] Baud and clock-out share reload pair
// [R16] Overflow flag only without serial clock; sticky
// [R17] Trigger falling edge captures or reloads, flags
// [R18] Serial clock bits force auto-reload
// [R19] Output enable turns count pin into output
// [R20] Clock-out pin toggles once per overflow
`timescale 1ns/1ps
`default_nettype none

module udt_timer
    import udt_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Pins
    input wire logic countPinIn,
    output logic countPinOut,
    output logic countPinOe_n,
    input wire logic directionPin,
    // Interrupt request and serial clocks
    output logic timerIrq,
    output logic rxBaudTick,
    output logic txBaudTick
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [7:0] control;
    logic [7:0] next_control;
    logic clockOutEn;
    logic next_clockOutEn;
    logic downCountEn;
    logic next_downCountEn;
    logic [7:0] countLow;
    logic [7:0] next_countLow;
    logic [7:0] countHigh;
    logic [7:0] next_countHigh;
    logic [15:0] reload;
    logic [15:0] next_reload;
    logic clockOut;
    logic next_clockOut;
    logic pinOe_n;
    logic next_pinOe_n;
    logic irq;
    logic next_irq;
    logic rxTick;
    logic next_rxTick;
    logic txTick;
    logic next_txTick;
    logic ack;
    logic next_ack;
    logic [31:0] rdData;
    logic [31:0] next_rdData;

    udt_tick_if ticks ();

    udt_tick_gen u_tick (
        .clock(clock),
        .arst_n(arst_n),
        .countPin(countPinIn),
        .directionPin(directionPin),
        .ticks(ticks)
    );

    // ------------------------------------------------------------
    // Decoded mode
    // ------------------------------------------------------------
    udt_op_t op;
    logic serialClk;
    logic clockOutMode;
    logic upDown;
    logic countUp;
    logic countTick;
    logic [15:0] count;
    logic lowAtMax;
    logic overflow;
    logic underflow;
    logic trigger;
    logic wrap;

    always_comb begin
        count = {countHigh, countLow};
        op = udt_decode_op(control[UDT_CTL_RECEIVE_CLOCK], control[UDT_CTL_TRANSMIT_CLOCK],
                           control[UDT_CTL_CAPTURE_RELOAD]);                        // [R4]
        serialClk = (op == UDT_OP_BAUD);
        clockOutMode = clockOutEn & ~control[UDT_CTL_COUNTER_SELECT];
        // Serial clocking ignores the down-count option
        upDown = downCountEn & (op == UDT_OP_RELOAD);
        countUp = ~upDown | directionPin;                                           // [R5]
        if (!control[UDT_CTL_RUN]) begin
            countTick = 1'b0;                                                       // [R3]
        end else if (control[UDT_CTL_COUNTER_SELECT]) begin
            countTick = ticks.countFall;                                            // [R2]
        end else if (serialClk || clockOutMode) begin
            countTick = ticks.halfTick;                                             // [R10]
        end else begin
            countTick = ticks.timerTick;                                            // [R2]
        end
        lowAtMax = (countLow == 8'hFF);
        overflow = countTick & countUp & (count == UDT_COUNT_ALL_ONES);             // [R6]
        underflow = countTick & ~countUp & (count == reload);                       // [R7]
        wrap = overflow | underflow;
        // Trigger edges are ignored while the timer clocks the serial port
        trigger = control[UDT_CTL_TRIGGER_ENABLE] & ticks.triggerFall & ~serialClk;  // [R17]
    end

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    logic request;
    logic wrCycle;

    always_comb begin
        request = wb_cyc_i & wb_stb_i & ~ack;
        wrCycle = request & wb_we_i & wb_sel_i[0];
        next_ack = request;
        next_rdData = 32'h0000_0000;
        if (request && !wb_we_i) begin
            if (wb_adr_i == UDT_OFS_CONTROL) begin
                next_rdData = {24'h00_0000, control};
            end else if (wb_adr_i == UDT_OFS_MODE) begin
                next_rdData = {30'h0000_0000, clockOutEn, downCountEn};
            end else if (wb_adr_i == UDT_OFS_COUNT_LOW) begin
                next_rdData = {24'h00_0000, countLow};
            end else if (wb_adr_i == UDT_OFS_COUNT_HIGH) begin
                next_rdData = {24'h00_0000, countHigh};
            end else if (wb_adr_i == UDT_OFS_RELOAD_LOW) begin
                next_rdData = {24'h00_0000, reload[7:0]};
            end else if (wb_adr_i == UDT_OFS_RELOAD_HIGH) begin
                next_rdData = {24'h00_0000, reload[15:8]};
            end else begin
                next_rdData = 32'h0000_0000;
            end
        end
    end

    // ------------------------------------------------------------
    // Counter, reload pair and flags
    // ------------------------------------------------------------
    always_comb begin
        next_countLow = countLow;
        next_countHigh = countHigh;
        next_reload = reload;
        next_control = control;
        next_clockOutEn = clockOutEn;
        next_downCountEn = downCountEn;

        // Count step; high byte moves on carry or borrow of the low byte
        if (countTick) begin
            if (countUp) begin
                if (overflow) begin
                    if (op == UDT_OP_CAPTURE) begin
                        {next_countHigh, next_countLow} = 16'h0000;
                    end else begin
                        {next_countHigh, next_countLow} = reload;                   // [R6] [R11] [R18]
                    end
                end else begin
                    next_countLow = countLow + 8'h01;
                    next_countHigh = lowAtMax ? countHigh + 8'h01 : countHigh;      // [R1]
                end
            end else if (underflow) begin
                {next_countHigh, next_countLow} = UDT_COUNT_ALL_ONES;               // [R7]
            end else begin
                next_countLow = countLow - 8'h01;
                next_countHigh = (countLow == 8'h00) ? countHigh - 8'h01 : countHigh; // [R1]
            end
        end

        if (trigger) begin
            if (op == UDT_OP_CAPTURE) begin
                next_reload = count;                                                // [R17]
            end else begin
                {next_countHigh, next_countLow} = reload;                           // [R17]
            end
        end

        // Software writes; a write to a count byte beats a step in the same cycle
        if (wrCycle) begin
            if (wb_adr_i == UDT_OFS_CONTROL) begin
                next_control = wb_dat_i[7:0];
            end else if (wb_adr_i == UDT_OFS_MODE) begin
                next_clockOutEn = wb_dat_i[UDT_MODE_CLOCK_OUT_EN];
                next_downCountEn = wb_dat_i[UDT_MODE_DOWN_COUNT_EN];
            end else if (wb_adr_i == UDT_OFS_COUNT_LOW) begin
                next_countLow = wb_dat_i[7:0];
            end else if (wb_adr_i == UDT_OFS_COUNT_HIGH) begin
                next_countHigh = wb_dat_i[7:0];
            end else if (wb_adr_i == UDT_OFS_RELOAD_LOW) begin
                next_reload[7:0] = wb_dat_i[7:0];
            end else if (wb_adr_i == UDT_OFS_RELOAD_HIGH) begin
                next_reload[15:8] = wb_dat_i[7:0];
            end
        end

        // Hardware sets win over a software clear in the same cycle
        if (wrap && !serialClk && !clockOutMode) begin
            next_control[UDT_CTL_OVERFLOW_FLAG] = 1'b1;                             // [R16] [R11]
        end
        if (upDown) begin
            if (wrap) begin
                next_control[UDT_CTL_EXTERNAL_FLAG] = ~control[UDT_CTL_EXTERNAL_FLAG]; // [R8]
            end
        end else if (trigger) begin
            next_control[UDT_CTL_EXTERNAL_FLAG] = 1'b1;                             // [R17]
        end
    end

    // ------------------------------------------------------------
    // Pin, interrupt and serial clock outputs
    // ------------------------------------------------------------
    always_comb begin
        // One toggle per overflow halves the overflow rate: 50% duty
        if (!clockOutMode) begin
            next_clockOut = 1'b0;
        end else if (overflow) begin
            next_clockOut = ~clockOut;                                              // [R9] [R12] [R20]
        end else begin
            next_clockOut = clockOut;
        end
        next_pinOe_n = ~next_clockOutEn;                                            // [R13] [R19]
        // External flag requests no interrupt in up/down mode
        next_irq = next_control[UDT_CTL_OVERFLOW_FLAG]
                 | (next_control[UDT_CTL_EXTERNAL_FLAG] & ~next_downCountEn);       // [R6] [R8]
        // Baud ticks share the reload pair with clock output
        next_rxTick = overflow & control[UDT_CTL_RECEIVE_CLOCK];                    // [R15]
        next_txTick = overflow & control[UDT_CTL_TRANSMIT_CLOCK];                   // [R15]
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            control <= UDT_CONTROL_RST;
            clockOutEn <= UDT_MODE_RST[UDT_MODE_CLOCK_OUT_EN];
            downCountEn <= UDT_MODE_RST[UDT_MODE_DOWN_COUNT_EN];
            countLow <= UDT_COUNT_RST[7:0];
            countHigh <= UDT_COUNT_RST[15:8];
            reload <= UDT_RELOAD_RST;
            clockOut <= 1'b0;
            pinOe_n <= 1'b1;
            irq <= 1'b0;
            rxTick <= 1'b0;
            txTick <= 1'b0;
            ack <= 1'b0;
            rdData <= 32'h0000_0000;
        end else begin
            control <= next_control;
            clockOutEn <= next_clockOutEn;
            downCountEn <= next_downCountEn;
            countLow <= next_countLow;
            countHigh <= next_countHigh;
            reload <= next_reload;
            clockOut <= next_clockOut;
            pinOe_n <= next_pinOe_n;
            irq <= next_irq;
            rxTick <= next_rxTick;
            txTick <= next_txTick;
            ack <= next_ack;
            rdData <= next_rdData;
        end
    end

    // ------------------------------------------------------------
    // Outputs straight from flops
    // ------------------------------------------------------------

    assign wb_ack_o = ack;
    assign wb_dat_o = rdData;
    assign countPinOut = clockOut;
    assign countPinOe_n = pinOe_n;
    assign timerIrq = irq;
    assign rxBaudTick = rxTick;
    assign txBaudTick = txTick;

endmodule // udt_timer

`default_nettype wire

// File: src/udt_pkg.sv
`default_nettype none

package udt_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses, one word each)
    // ------------------------------------------------------------
    localparam logic [7:0] UDT_OFS_CONTROL = 8'h00;
    localparam logic [7:0] UDT_OFS_MODE = 8'h04;
    localparam logic [7:0] UDT_OFS_COUNT_LOW = 8'h08;
    localparam logic [7:0] UDT_OFS_COUNT_HIGH = 8'h0C;
    localparam logic [7:0] UDT_OFS_RELOAD_LOW = 8'h10;
    localparam logic [7:0] UDT_OFS_RELOAD_HIGH = 8'h14;

    // ------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------
    localparam int UDT_CTL_OVERFLOW_FLAG = 7;
    localparam int UDT_CTL_EXTERNAL_FLAG = 6;
    localparam int UDT_CTL_RECEIVE_CLOCK = 5;
    localparam int UDT_CTL_TRANSMIT_CLOCK = 4;
    localparam int UDT_CTL_TRIGGER_ENABLE = 3;
    localparam int UDT_CTL_RUN = 2;
    localparam int UDT_CTL_COUNTER_SELECT = 1;
    localparam int UDT_CTL_CAPTURE_RELOAD = 0;

    // ------------------------------------------------------------
    // Mode register fields
    // ------------------------------------------------------------
    localparam int UDT_MODE_CLOCK_OUT_EN = 1;
    localparam int UDT_MODE_DOWN_COUNT_EN = 0;

    // ------------------------------------------------------------
    // Reset values and limits
    // ------------------------------------------------------------
    localparam logic [7:0] UDT_CONTROL_RST = 8'h00;
    localparam logic [1:0] UDT_MODE_RST = 2'h0;
    localparam logic [15:0] UDT_COUNT_RST = 16'h0000;
    localparam logic [15:0] UDT_RELOAD_RST = 16'h0000;
    localparam logic [15:0] UDT_COUNT_ALL_ONES = 16'hFFFF;

    // ------------------------------------------------------------
    // Timing counts
    // ------------------------------------------------------------
    localparam int UDT_TIMER_DIV = 12;
    localparam int UDT_HALF_DIV = 2;
    localparam logic [3:0] UDT_TIMER_LAST = 4'(UDT_TIMER_DIV - 1);
    localparam logic [0:0] UDT_HALF_LAST = 1'(UDT_HALF_DIV - 1);

    typedef enum logic [1:0] {
        UDT_OP_CAPTURE = 2'b00,
        UDT_OP_RELOAD = 2'b01,
        UDT_OP_BAUD = 2'b10
    } udt_op_t;

    function automatic udt_op_t udt_decode_op(input logic rxClk, input logic txClk,
                                              input logic captureSel);
        udt_op_t op;
        if (rxClk || txClk) begin
            op = UDT_OP_BAUD;
        end else if (captureSel) begin
            op = UDT_OP_CAPTURE;
        end else begin
            op = UDT_OP_RELOAD;
        end
        return op;
    endfunction

endpackage

`default_nettype wire

// File: src/udt_tick_if.sv
`timescale 1ns/1ps
`default_nettype none

// Count events from the prescaler and pin edge detectors
interface udt_tick_if;
    logic timerTick;
    logic halfTick;
    logic countFall;
    logic triggerFall;

    modport src (output timerTick, output halfTick, output countFall, output triggerFall);
    modport snk (input timerTick, input halfTick, input countFall, input triggerFall);
endinterface

`default_nettype wire

// File: src/udt_tick_gen.sv
`timescale 1ns/1ps
`default_nettype none

module udt_tick_gen
    import udt_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Pins
    input wire logic countPin,
    input wire logic directionPin,
    // Events
    udt_tick_if.src ticks
);

    logic [3:0] prescale;
    logic [3:0] next_prescale;
    logic half;
    logic next_half;
    logic countPrev;
    logic triggerPrev;
    logic timerTick;
    logic next_timerTick;
    logic halfTick;
    logic next_halfTick;
    logic countFall;
    logic next_countFall;
    logic triggerFall;
    logic next_triggerFall;

    always_comb begin
        next_prescale = (prescale == UDT_TIMER_LAST) ? 4'h0 : prescale + 4'h1;
        next_timerTick = (prescale == UDT_TIMER_LAST);
        next_half = (half == UDT_HALF_LAST) ? 1'b0 : half + 1'b1;
        next_halfTick = (half == UDT_HALF_LAST);
        // Falling edges only; reset level high avoids a false first edge
        next_countFall = countPrev & ~countPin;
        next_triggerFall = triggerPrev & ~directionPin;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            prescale <= 4'h0;
            half <= 1'b0;
            countPrev <= 1'b1;
            triggerPrev <= 1'b1;
            timerTick <= 1'b0;
            halfTick <= 1'b0;
            countFall <= 1'b0;
            triggerFall <= 1'b0;
        end else begin
            prescale <= next_prescale;
            half <= next_half;
            countPrev <= countPin;
            triggerPrev <= directionPin;
            timerTick <= next_timerTick;
            halfTick <= next_halfTick;
            countFall <= next_countFall;
            triggerFall <= next_triggerFall;
        end
    end

    assign ticks.timerTick = timerTick;
    assign ticks.halfTick = halfTick;
    assign ticks.countFall = countFall;
    assign ticks.triggerFall = triggerFall;

endmodule // udt_tick_gen

`default_nettype wire

// File: verification/udt_timer_props.sv
`timescale 1ns/1ps
`default_nettype none

module udt_timer_props (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Pins and events
    input wire logic countPinOut,
    input wire logic countPinOe_n,
    input wire logic timerIrq,
    input wire logic rxBaudTick,
    input wire logic txBaudTick
);
    default clocking @(posedge clock); endclocking
    default disable iff (!arst_n);

    // ------------------------------------------------------------
    // Bus answers
    // ------------------------------------------------------------
    a_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("ack missing one cycle after request");
    a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");

    // ------------------------------------------------------------
    // Pins, flags and serial ticks
    // ------------------------------------------------------------
    a_oe_quiet: assert property (countPinOe_n && $past(countPinOe_n) |-> !countPinOut)
        else $error("clock out moves while pin released");
    a_half_min: assert property ($changed(countPinOut) |=> $stable(countPinOut))
        else $error("clock out half period below two cycles");
    a_irq_clear: assert property ($fell(timerIrq) |->
        $past(wb_we_i && wb_stb_i, 1) || $past(wb_we_i && wb_stb_i, 2))
        else $error("interrupt dropped without a write");
    a_baud_noirq: assert property (rxBaudTick |-> !$rose(timerIrq) ##1 !$rose(timerIrq))
        else $error("interrupt raised by a serial clock overflow");
    a_rx_pulse: assert property (rxBaudTick |=> !rxBaudTick)
        else $error("receive tick wider than one cycle");
    a_tx_pulse: assert property (txBaudTick |=> !txBaudTick)
        else $error("transmit tick wider than one cycle");

    c_clock_out: cover property ($rose(countPinOut));
    c_baud_tick: cover property (rxBaudTick && txBaudTick);
    c_irq_clear: cover property ($fell(timerIrq));
endmodule // udt_timer_props

bind udt_timer udt_timer_props props_u (.clock(clock), .arst_n(arst_n), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .countPinOut(countPinOut), .countPinOe_n(countPinOe_n), .timerIrq(timerIrq),
    .rxBaudTick(rxBaudTick), .txBaudTick(txBaudTick));

`default_nettype wire

// File: verification/udt_pin_model.sv
`timescale 1ns/1ps
`default_nettype none

module udt_pin_model (
    // Clock
    input wire logic clock,
    // Levels asked by the bench
    input wire logic extLevel,
    input wire logic dirLevel,
    // Device side
    input wire logic countPinOut,
    input wire logic countPinOe_n,
    output logic countPinIn,
    output logic directionPin,
    output var int lastHalf
);
    logic prevPin = 1'b1;
    int gap = 0;

    // Device owns the wire while enabled; outside source yields
    assign countPinIn = countPinOe_n ? extLevel : countPinOut;
    assign directionPin = dirLevel;

    // Cycles between wire changes, read back as half period
    always @(posedge clock) begin
        prevPin <= countPinIn;
        if (countPinIn !== prevPin) begin
            lastHalf <= gap;
            gap <= 1;
        end else begin
            gap <= gap + 1;
        end
    end
endmodule // udt_pin_model

`default_nettype wire

// File: verification/udt_timer_bench.sv
`timescale 1ns/1ps
`default_nettype none

module udt_timer_bench;
    import udt_pkg::*;
    logic clock = 1'b0;
    logic arst_n, wbCyc, wbStb, wbWe, wbAck, pinIn, pinOut, pinOe_n, dirPin;
    logic irq, rxTick, txTick, extLevel, dirLevel;
    logic [7:0] wbAdr, v, u;
    logic [31:0] wbDatW, wbDatR;
    int lastHalf, rxSeen, txSeen;
    int nErrors = 0;
    int checkCount = 0;

    always #2.5 clock = ~clock;

    udt_timer dut_u (.clock(clock), .arst_n(arst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
        .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatW),
        .wb_dat_o(wbDatR), .wb_ack_o(wbAck), .countPinIn(pinIn), .countPinOut(pinOut),
        .countPinOe_n(pinOe_n), .directionPin(dirPin), .timerIrq(irq),
        .rxBaudTick(rxTick), .txBaudTick(txTick));
    udt_pin_model pins_u (.clock(clock), .extLevel(extLevel), .dirLevel(dirLevel),
        .countPinOut(pinOut), .countPinOe_n(pinOe_n), .countPinIn(pinIn),
        .directionPin(dirPin), .lastHalf(lastHalf));

    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        checkCount++;
        if (seen !== exp) begin
            nErrors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic closeOut;
        if (nErrors == 0 && checkCount > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask

    // Entered just after a rising edge; holds until ack is sampled
    task automatic bus(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                       output logic [7:0] rd);
        int n;
        n = 0;
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbDatW <= {24'h0, wd};
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'b1);
        check("bus latency", 16'(n), 16'h0002);
        rd = wbDatR[7:0];
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        wbWe <= 1'b0;
        @(posedge clock);
    endtask

    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        logic [7:0] t;
        bus(1'b1, adr, d, t);
    endtask

    task automatic rd(input logic [7:0] adr, output logic [7:0] d);
        bus(1'b0, adr, 8'h00, d);
    endtask

    task automatic set16(input logic [7:0] lo, input logic [15:0] val);
        wr(lo, val[7:0]);
        wr(lo + 8'h04, val[15:8]);
    endtask

    task automatic chk16(input string what, input logic [7:0] lo, input logic [15:0] exp);
        logic [7:0] l, h;
        rd(lo, l);
        rd(lo + 8'h04, h);
        check(what, {h, l}, exp);
    endtask

    task automatic falls(input int n);
        repeat (n) begin
            extLevel <= 1'b0;
            repeat (3) @(posedge clock);
            extLevel <= 1'b1;
            repeat (3) @(posedge clock);
        end
    endtask

    task automatic ticks(input int n);
        rxSeen = 0;
        txSeen = 0;
        repeat (n) begin
            @(posedge clock);
            if (rxTick === 1'b1) rxSeen++;
            if (txTick === 1'b1) txSeen++;
        end
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    initial begin
        {arst_n, wbCyc, wbStb, wbWe, wbAdr, wbDatW} = '0;
        extLevel = 1'b1;
        dirLevel = 1'b1;
        repeat (2) @(posedge clock);
        arst_n <= 1'b1;
        @(posedge clock);
        check("released pin", {15'h0, pinOe_n}, 16'h1);
        for (int a = 0; a <= 8'h20; a += 4) begin
            rd(8'(a), v);
            check("reset value", {8'h0, v}, 16'h0);
        end
        wr(8'h20, 8'h5A);
        rd(8'h20, v);
        check("unmapped", {8'h0, v}, 16'h0);
        // Timer mode, 12 clocks a step; hold when stopped
        wr(UDT_OFS_CONTROL, 8'h04);
        repeat (120) @(posedge clock);
        wr(UDT_OFS_CONTROL, 8'h00);
        rd(UDT_OFS_COUNT_LOW, v);
        check("timer steps", {15'h0, v >= 8'h09 && v <= 8'h0B}, 16'h1);
        repeat (60) @(posedge clock);
        rd(UDT_OFS_COUNT_LOW, u);
        check("held count", {8'h0, u}, {8'h0, v});
        // Counter mode: carry, overflow, reload, sticky flag
        wr(UDT_OFS_CONTROL, 8'h06);
        set16(UDT_OFS_COUNT_LOW, 16'h00FF);
        falls(1);
        chk16("carry", UDT_OFS_COUNT_LOW, 16'h0100);
        set16(UDT_OFS_RELOAD_LOW, 16'h1234);
        set16(UDT_OFS_COUNT_LOW, 16'hFFFE);
        falls(2);
        chk16("up reload", UDT_OFS_COUNT_LOW, 16'h1234);
        repeat (20) @(posedge clock);
        rd(UDT_OFS_CONTROL, v);
        check("overflow flag", {8'h0, v}, 16'h0086);
        check("irq", {15'h0, irq}, 16'h1);
        wr(UDT_OFS_CONTROL, 8'h06);
        repeat (3) @(posedge clock);
        check("irq cleared", {15'h0, irq}, 16'h0);
        // Up/down: underflow at reload, wrap toggles external flag
        wr(UDT_OFS_MODE, 8'h01);
        dirLevel <= 1'b0;
        set16(UDT_OFS_RELOAD_LOW, 16'h0010);
        set16(UDT_OFS_COUNT_LOW, 16'h0011);
        falls(1);
        chk16("down step", UDT_OFS_COUNT_LOW, 16'h0010);
        falls(1);
        chk16("underflow", UDT_OFS_COUNT_LOW, 16'hFFFF);
        rd(UDT_OFS_CONTROL, v);
        check("wrap flags", {8'h0, v}, 16'h00C6);
        wr(UDT_OFS_CONTROL, 8'h46);
        repeat (3) @(posedge clock);
        check("no ext irq", {15'h0, irq}, 16'h0);
        dirLevel <= 1'b1;
        falls(1);
        chk16("up wrap", UDT_OFS_COUNT_LOW, 16'h0010);
        rd(UDT_OFS_CONTROL, v);
        check("toggle back", {8'h0, v}, 16'h0086);
        wr(UDT_OFS_MODE, 8'h00);
        // Trigger edge: reload, then capture
        wr(UDT_OFS_CONTROL, 8'h0E);
        set16(UDT_OFS_RELOAD_LOW, 16'h0055);
        set16(UDT_OFS_COUNT_LOW, 16'h0100);
        dirLevel <= 1'b0;
        repeat (4) @(posedge clock);
        dirLevel <= 1'b1;
        chk16("trigger reload", UDT_OFS_COUNT_LOW, 16'h0055);
        rd(UDT_OFS_CONTROL, v);
        check("trigger flag", {8'h0, v}, 16'h004E);
        wr(UDT_OFS_CONTROL, 8'h0F);
        set16(UDT_OFS_COUNT_LOW, 16'h0777);
        dirLevel <= 1'b0;
        repeat (4) @(posedge clock);
        dirLevel <= 1'b1;
        chk16("capture", UDT_OFS_RELOAD_LOW, 16'h0777);
        set16(UDT_OFS_COUNT_LOW, 16'hFFFF);
        falls(1);
        chk16("capture wrap", UDT_OFS_COUNT_LOW, 16'h0000);
        // Serial clocks force reload even with capture selected
        wr(UDT_OFS_CONTROL, 8'h00);
        set16(UDT_OFS_RELOAD_LOW, 16'hFFF0);
        set16(UDT_OFS_COUNT_LOW, 16'hFFF0);
        wr(UDT_OFS_CONTROL, 8'h35);
        ticks(200);
        check("baud ticks", {15'h0, rxSeen >= 5 && rxSeen <= 7}, 16'h1);
        rd(UDT_OFS_CONTROL, v);
        check("no flag", {8'h0, v}, 16'h0035);
        // Clock output beside transmit clock, set up in order
        wr(UDT_OFS_CONTROL, 8'h00);
        wr(UDT_OFS_MODE, 8'h02);
        set16(UDT_OFS_RELOAD_LOW, 16'hFFFC);
        set16(UDT_OFS_COUNT_LOW, 16'hFFFC);
        wr(UDT_OFS_CONTROL, 8'h14);
        ticks(64);
        check("half period", 16'(lastHalf), 16'h0008);
        check("pin driven", {15'h0, pinOe_n}, 16'h0);
        check("shared", {15'h0, txSeen >= 7 && txSeen <= 9}, 16'h1);
        rd(UDT_OFS_CONTROL, v);
        check("clock out flag", {8'h0, v}, 16'h0014);
        check("clock out irq", {15'h0, irq}, 16'h0);
        closeOut();
    end

    // Whole run is about 750 cycles
    initial begin
        repeat (20000) @(posedge clock);
        nErrors++;
        closeOut();
    end
endmodule // udt_timer_bench

`default_nettype wire
